// ---- core/fcs_pkg.sv ----
// Shared constants and types of the cooling fan speed controller.
`default_nettype none
package fcs_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_FREQ_HZ = 25_000;
    localparam int PWM_STEPS = 255;
    localparam int PWM_STEP_CYC = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
    localparam int PRE_W = $clog2(PWM_STEP_CYC);
    localparam int SPEED_WIN_MS = 1000;
    localparam int SPEED_WIN_CYC = (CLK_HZ / 1000) * SPEED_WIN_MS;
    localparam int RPM_PER_COUNT = 60_000 / SPEED_WIN_MS;
    localparam int STALL_MS = 500;
    localparam int STALL_CYC = (CLK_HZ / 1000) * STALL_MS;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_ENABLE = 12'h000;
    localparam logic [11:0] ADDR_INT_EN = 12'h004;
    localparam logic [11:0] ADDR_INT_STAT = 12'h008;
    localparam logic [11:0] ADDR_CH_BASE = 12'h010;
    localparam int CH_SHIFT = 4;
    localparam logic [1:0] CH_CFG = 2'h0;
    localparam logic [1:0] CH_DUTY = 2'h1;
    localparam logic [1:0] CH_TARGET = 2'h2;
    localparam logic [1:0] CH_RPM = 2'h3;
    localparam int INT_STALL_LSB = 0;
    localparam int INT_REACHED_LSB = 8;
    // ------------------------------------------------------------
    // Channel configuration fields
    // ------------------------------------------------------------
    localparam int CFG_W = 15;
    localparam int CFG_AUTO_BIT = 0;
    localparam int CFG_NORESTART_BIT = 1;
    localparam int CFG_FAST_BIT = 2;
    localparam int CFG_START_LSB = 3;
    localparam int CFG_SEDGE_LSB = 5;
    localparam int CFG_SPACING_LSB = 8;
    localparam int CFG_AVG_LSB = 11;
    localparam int CFG_PPR_LSB = 13;
    localparam logic [14:0] CFG_RST = 15'h0000;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [15:0] TARGET_RST = 16'h0000;
    // ------------------------------------------------------------
    // Duty values and loop tuning
    // ------------------------------------------------------------
    localparam logic [7:0] DUTY_50 = 8'h80;
    localparam logic [7:0] DUTY_75 = 8'hBF;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] RAMP_SLOW_STEP = 8'h01;
    localparam logic [7:0] RAMP_FAST_STEP = 8'h08;
    localparam logic [16:0] RPM_TOL = 17'h0003C;
    typedef enum logic [1:0] {
        LOOP_OFF = 2'b00,
        LOOP_START = 2'b01,
        LOOP_RUN = 2'b10,
        LOOP_STALL = 2'b11
    } fcs_loop_t;
endpackage
`default_nettype wire

// ---- core/fcs_tach.sv ----
// Tachometer meter of one channel: speed in RPM, edge pulses, stall detection.
`timescale 1ns/1ns
`default_nettype none
module fcs_tach #(
    parameter int WIN_CYC = fcs_pkg::SPEED_WIN_CYC, // Speed window at one pulse per rev.
    parameter int STALL_CYC = fcs_pkg::STALL_CYC // Cycles without an edge that mean stall.
) (
    input wire logic ref_clk, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic chan_on, // Channel enabled.
    input wire logic drive_on, // PWM output is driving the fan.
    input wire logic tach_in, // Tachometer input.
    input wire logic [1:0] ppr_log, // Log2 of tach pulses per revolution.
    input wire logic [1:0] avg_log, // Log2 of samples averaged, zero for none.
    output logic tach_edge, // One-cycle pulse per rising tach edge.
    output logic stall_evt, // One-cycle pulse when a stall is declared.
    output logic [15:0] rpm // Measured speed.
);
    import fcs_pkg::*;
    localparam int WW = $clog2(WIN_CYC + 1);
    localparam int SW = $clog2(STALL_CYC + 1);
    typedef struct packed {
        logic tach_q;
        logic rise;
        logic [WW-1:0] win;
        logic [15:0] pulses;
        logic [18:0] acc;
        logic [3:0] nsamp;
        logic [15:0] rpm;
        logic [SW-1:0] idle;
        logic stalled;
        logic stall;
    } fcs_tach_st_t;
    fcs_tach_st_t s_reg, s_next;
    logic [WW-1:0] win_len;
    logic [18:0] sum;
    logic [31:0] speed;

    // ------------------------------------------------------------
    // Measurement and stall logic
    // ------------------------------------------------------------
    // A shorter window per extra pulse keeps the RPM scale a plain constant.
    always_comb begin
        s_next = s_reg;
        win_len = WW'(WIN_CYC >> ppr_log);
        sum = s_reg.acc + 19'(s_reg.pulses);
        speed = 32'(sum >> avg_log) * 32'(RPM_PER_COUNT);
        s_next.rise = tach_in && !s_reg.tach_q;
        s_next.tach_q = tach_in;
        s_next.stall = 1'b0;
        if (!chan_on) begin
            s_next = '0;
            s_next.tach_q = tach_in;
        end else begin
            if (s_reg.win >= win_len - WW'(1)) begin
                s_next.win = '0;
                s_next.pulses = 16'(s_next.rise);
                if (s_reg.nsamp >= (4'h1 << avg_log) - 4'h1) begin
                    s_next.rpm = (speed > 32'h0000FFFF) ? 16'hFFFF : speed[15:0];
                    s_next.acc = '0;
                    s_next.nsamp = '0;
                end else begin
                    s_next.acc = sum;
                    s_next.nsamp = s_reg.nsamp + 4'h1;
                end
            end else begin
                s_next.win = s_reg.win + WW'(1);
                s_next.pulses = s_reg.pulses + 16'(s_next.rise);
            end
            // One stall pulse per silence; the next edge or a cycle without drive re-arms it.
            if (s_next.rise || !drive_on) begin
                s_next.idle = '0;
                s_next.stalled = 1'b0;
            end else if (!s_reg.stalled) begin
                if (s_reg.idle == SW'(STALL_CYC - 1)) begin
                    s_next.stall = 1'b1;
                    s_next.stalled = 1'b1;
                end else begin
                    s_next.idle = s_reg.idle + SW'(1);
                end
            end
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tach_edge = s_reg.rise;
    assign stall_evt = s_reg.stall;
    assign rpm = s_reg.rpm;
endmodule // fcs_tach
`default_nettype wire

// ---- core/fcs_top.sv ----
// Multi-channel cooling fan speed controller with APB registers.
`timescale 1ns/1ns
`default_nettype none
module fcs_top #(
    parameter int NCH = 4, // Number of fan channels, at most eight.
    parameter int WIN_CYC = fcs_pkg::SPEED_WIN_CYC, // Speed window length in cycles.
    parameter int STALL_CYC = fcs_pkg::STALL_CYC // Stall timeout in cycles.
) (
    input wire logic ref_clk, // System clock, 100 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic [fcs_pkg::ADDR_W-1:0] paddr, // APB byte address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write when high.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic [NCH-1:0] tach_in, // Tachometer inputs, one per fan.
    output logic [NCH-1:0] pwm_out, // PWM drive, one per fan.
    output logic irq // Interrupt request, active high.
);
    import fcs_pkg::*;
    typedef struct packed {
        logic [NCH-1:0] en;
        logic [NCH-1:0][CFG_W-1:0] cfg;
        logic [NCH-1:0][7:0] mduty;
        logic [NCH-1:0][15:0] target;
        logic [NCH-1:0][7:0] aduty;
        fcs_loop_t [NCH-1:0] loop;
        logic [NCH-1:0][8:0] ecnt;
        logic [NCH-1:0] at_speed;
        logic [31:0] int_en;
        logic [31:0] int_st;
        logic [PRE_W-1:0] pre;
        logic [7:0] pcnt;
        logic [NCH-1:0] pwm;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } fcs_state_t;
    fcs_state_t s_reg, s_next;

    logic [NCH-1:0] tedge;
    logic [NCH-1:0] stall;
    logic [NCH-1:0][15:0] rpm;
    logic [NCH-1:0][7:0] eff;
    logic [31:0] int_mask;
    logic [31:0] int_set;
    logic [31:0] int_clr;
    logic [31:0] rdat;
    logic [ADDR_W-1:0] off;
    logic [1:0] sel;
    logic hit;
    logic wr;
    logic setup;
    int chi;
    logic auto_m;
    logic [1:0] sdsel;
    logic [8:0] sedges;
    logic [8:0] spacing;
    logic [7:0] step;
    logic [7:0] kick;
    logic go_up;
    logic go_dn;
    logic at;

    // ------------------------------------------------------------
    // Per-channel tachometer meters
    // ------------------------------------------------------------
    // Each channel owns its meter, so channels never interact.
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        fcs_tach #(
            .WIN_CYC(WIN_CYC),
            .STALL_CYC(STALL_CYC)
        ) u_tach (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .chan_on(s_reg.en[g]),
            .drive_on(s_reg.en[g] && (eff[g] != 8'h00)),
            .tach_in(tach_in[g]),
            .ppr_log(s_reg.cfg[g][CFG_PPR_LSB +: 2]),
            .avg_log(s_reg.cfg[g][CFG_AVG_LSB +: 2]),
            .tach_edge(tedge[g]),
            .stall_evt(stall[g]),
            .rpm(rpm[g])
        );
    end

    // ------------------------------------------------------------
    // Effective duty and event mask layout
    // ------------------------------------------------------------
    // A disabled channel drives zero duty; manual mode uses the written duty.
    always_comb begin
        int_mask = '0;
        for (int i = 0; i < NCH; i++) begin
            int_mask[INT_STALL_LSB + i] = 1'b1;
            int_mask[INT_REACHED_LSB + i] = 1'b1;
            if (!s_reg.en[i]) begin
                eff[i] = 8'h00;
            end else if (s_reg.cfg[i][CFG_AUTO_BIT]) begin
                eff[i] = s_reg.aduty[i];
            end else begin
                eff[i] = s_reg.mduty[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Next-state logic: bus slave, control loops, events, PWM
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        setup = psel && !penable;
        wr = psel && penable && s_reg.pready && pwrite;
        int_set = '0;
        int_clr = '0;
        rdat = '0;
        hit = 1'b1;
        chi = 0;
        off = paddr - ADDR_CH_BASE;
        sel = paddr[3:2];
        auto_m = 1'b0;
        sdsel = 2'b00;
        sedges = 9'h000;
        spacing = 9'h000;
        step = 8'h00;
        kick = 8'h00;
        go_up = 1'b0;
        go_dn = 1'b0;
        at = 1'b0;

        // Address decode; reads are sampled in the setup cycle.
        if (paddr == ADDR_ENABLE) begin
            rdat = 32'(s_reg.en);
            if (wr) begin
                s_next.en = pwdata[NCH-1:0];
            end
        end else if (paddr == ADDR_INT_EN) begin
            rdat = s_reg.int_en;
            if (wr) begin
                s_next.int_en = pwdata & int_mask;
            end
        end else if (paddr == ADDR_INT_STAT) begin
            rdat = s_reg.int_st;
            if (wr) begin
                int_clr = pwdata;
            end
        end else if (paddr >= ADDR_CH_BASE && (off >> CH_SHIFT) < ADDR_W'(NCH)
                     && paddr[1:0] == 2'b00) begin
            chi = int'(off >> CH_SHIFT);
            case (sel)
                CH_CFG: begin
                    rdat = 32'(s_reg.cfg[chi]);
                    if (wr) begin
                        s_next.cfg[chi] = pwdata[CFG_W-1:0];
                    end
                end
                CH_DUTY: begin
                    if (s_reg.cfg[chi][CFG_AUTO_BIT]) begin
                        rdat = 32'(s_reg.aduty[chi]);
                    end else begin
                        rdat = 32'(s_reg.mduty[chi]);
                    end
                    if (wr) begin
                        s_next.mduty[chi] = pwdata[7:0];
                    end
                end
                CH_TARGET: begin
                    rdat = 32'(s_reg.target[chi]);
                    if (wr) begin
                        s_next.target[chi] = pwdata[15:0];
                    end
                end
                default: begin
                    rdat = {14'h0000, s_reg.loop[chi], rpm[chi]};
                end
            endcase
        end else begin
            hit = 1'b0;
        end
        s_next.pready = setup;
        s_next.pslverr = setup && !hit;
        s_next.prdata = (setup && !pwrite) ? rdat : 32'h00000000;

        // Closed-loop control, one pass per channel.
        for (int i = 0; i < NCH; i++) begin
            auto_m = s_reg.cfg[i][CFG_AUTO_BIT];
            // Cleared per channel so an idle channel never inherits a neighbour's state.
            at = 1'b0;
            sdsel = s_reg.cfg[i][CFG_START_LSB +: 2];
            sedges = 9'h002 << s_reg.cfg[i][CFG_SEDGE_LSB +: 3];
            spacing = 9'h001 << s_reg.cfg[i][CFG_SPACING_LSB +: 3];
            step = s_reg.cfg[i][CFG_FAST_BIT] ? RAMP_FAST_STEP : RAMP_SLOW_STEP;
            case (sdsel)
                2'b01: kick = DUTY_50;
                2'b10: kick = DUTY_75;
                default: kick = DUTY_FULL;
            endcase
            go_up = ({1'b0, rpm[i]} + RPM_TOL) < {1'b0, s_reg.target[i]};
            go_dn = {1'b0, rpm[i]} > ({1'b0, s_reg.target[i]} + RPM_TOL);
            // Manual mode keeps the loop idle, so its options have no effect.
            if (!s_reg.en[i] || !auto_m) begin
                s_next.loop[i] = LOOP_OFF;
                s_next.ecnt[i] = 9'h000;
            end else begin
                case (s_reg.loop[i])
                    LOOP_OFF: begin
                        s_next.ecnt[i] = 9'h000;
                        if (sdsel != 2'b00) begin
                            s_next.loop[i] = LOOP_START;
                            s_next.aduty[i] = kick;
                        end else begin
                            s_next.loop[i] = LOOP_RUN;
                        end
                    end
                    LOOP_START: begin
                        if (tedge[i]) begin
                            if (s_reg.ecnt[i] + 9'h001 >= sedges) begin
                                s_next.loop[i] = LOOP_RUN;
                                s_next.ecnt[i] = 9'h000;
                            end else begin
                                s_next.ecnt[i] = s_reg.ecnt[i] + 9'h001;
                            end
                        end
                    end
                    LOOP_RUN: begin
                        if (tedge[i]) begin
                            if (s_reg.ecnt[i] + 9'h001 >= spacing) begin
                                s_next.ecnt[i] = 9'h000;
                                if (go_up) begin
                                    s_next.aduty[i] = (s_reg.aduty[i] > DUTY_FULL - step) ?
                                        DUTY_FULL : s_reg.aduty[i] + step;
                                end else if (go_dn) begin
                                    s_next.aduty[i] = (s_reg.aduty[i] < step) ?
                                        8'h00 : s_reg.aduty[i] - step;
                                end
                            end else begin
                                s_next.ecnt[i] = s_reg.ecnt[i] + 9'h001;
                            end
                        end
                    end
                    default: begin
                        s_next.aduty[i] = 8'h00;
                    end
                endcase
                // A stall either parks the channel or kicks it again.
                if (stall[i] && s_reg.loop[i] != LOOP_STALL) begin
                    s_next.ecnt[i] = 9'h000;
                    if (s_reg.cfg[i][CFG_NORESTART_BIT]) begin
                        s_next.loop[i] = LOOP_STALL;
                        s_next.aduty[i] = 8'h00;
                    end else begin
                        s_next.loop[i] = (sdsel != 2'b00) ? LOOP_START : LOOP_RUN;
                        s_next.aduty[i] = kick;
                    end
                end
                at = (s_reg.loop[i] == LOOP_RUN) && !go_up && !go_dn;
            end
            s_next.at_speed[i] = at;
            int_set[INT_STALL_LSB + i] = s_reg.en[i] && stall[i];
            int_set[INT_REACHED_LSB + i] = at && !s_reg.at_speed[i];
        end

        // A new event wins over a clear written in the same cycle.
        s_next.int_st = ((s_reg.int_st & ~int_clr) | int_set) & int_mask;
        s_next.irq = |(s_next.int_st & s_reg.int_en);

        // PWM time base: one step per prescaler wrap, 255 steps per period.
        if (s_reg.pre == PRE_W'(PWM_STEP_CYC - 1)) begin
            s_next.pre = '0;
            if (s_reg.pcnt == 8'(PWM_STEPS - 1)) begin
                s_next.pcnt = 8'h00;
            end else begin
                s_next.pcnt = s_reg.pcnt + 8'h01;
            end
        end else begin
            s_next.pre = s_reg.pre + PRE_W'(1);
        end
        // Full duty never drops low because the step count stops one short.
        for (int i = 0; i < NCH; i++) begin
            s_next.pwm[i] = eff[i] > s_reg.pcnt;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset leaves every channel disabled with its outputs low.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                s_reg.cfg[i] <= CFG_RST;
                s_reg.mduty[i] <= DUTY_RST;
                s_reg.target[i] <= TARGET_RST;
            end
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign pwm_out = s_reg.pwm;
    assign irq = s_reg.irq;
endmodule // fcs_top
`default_nettype wire

// ---- bench/fcs_properties.sv ----
// Port-level assertions of the fan controller, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module fcs_properties #(
    parameter int NCH = 4 // Number of fan channels.
) (
    input wire logic ref_clk, // Clock.
    input wire logic rstn, // Reset, active low.
    input wire logic [fcs_pkg::ADDR_W-1:0] paddr, // Address.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Write.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic [NCH-1:0] tach_in, // Tach inputs.
    input wire logic [NCH-1:0] pwm_out, // PWM outputs.
    input wire logic irq // Interrupt.
);
    import fcs_pkg::*;
    logic wr;
    logic [NCH-1:0] en_q;
    logic [15:0] ie_q;
    // Completed writes; the shadows below follow the enable registers.
    assign wr = psel && penable && pready && pwrite;
    // Shadows change on the access edge, the same edge the block updates on.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            en_q <= '0;
            ie_q <= '0;
        end else if (wr && paddr == ADDR_ENABLE) begin
            en_q <= pwdata[NCH-1:0];
        end else if (wr && paddr == ADDR_INT_EN) begin
            ie_q <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence setup_s;
        psel && !penable;
    endsequence
    // Bus handshake: one wait-free access after every setup cycle.
    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("ready missing after setup");
    ready_only_access_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access");
    idle_rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    unmapped_error_a: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
        else $error("unmapped address accepted");
    // Settling takes a register stage, so the level is judged after three cycles.
    disabled_low_a: assert property (!en_q[0] [*3] |-> !pwm_out[0])
        else $error("disabled channel drives");
    irq_masked_a: assert property (ie_q == 16'h0 [*3] |-> !irq)
        else $error("masked event raised irq");
    irq_latched_a: assert property (irq && !wr && !$past(wr) |=> irq)
        else $error("event dropped without clear");
endmodule // fcs_properties
`default_nettype wire

// ---- bench/fcs_fan_model.sv ----
// Behavioural cooling fan: spins while driven, gives a tach square wave.
`timescale 1ns/1ns
`default_nettype none
module fcs_fan_model #(
    parameter int HALF = 20 // Half tach period in cycles.
) (
    input wire logic ref_clk, // Clock.
    input wire logic pwm, // Drive from the controller.
    input wire logic stop, // Jams the rotor.
    output logic tach // Tach output.
);
    int idle = 9999;
    int cnt = 0;
    logic t = 1'b0;
    assign tach = t;
    // The rotor coasts through low PWM phases but stops once drive is gone a while.
    always @(posedge ref_clk) begin
        idle <= pwm ? 0 : (idle < 9999 ? idle + 1 : idle);
        if (stop || idle > 4000) begin
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            t <= !t;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // fcs_fan_model
`default_nettype wire

// ---- bench/test_cooling_fan_speed_controller.sv ----
// Self-checking testbench of the fan controller over APB with fan models.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module test_cooling_fan_speed_controller;
    import fcs_pkg::*;
    localparam int HALF = 20;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] tach_in, pwm_out, stop;
    int failures = 0;
    int checked = 0;
    int hi, n;
    fcs_top #(.NCH(4), .WIN_CYC(2000), .STALL_CYC(500)) u_dut (.ref_clk(ref_clk),
        .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tach_in(tach_in), .pwm_out(pwm_out), .irq(irq));
    for (genvar i = 0; i < 4; i++) begin : g_fan
        fcs_fan_model #(.HALF(HALF)) u_fan (.ref_clk(ref_clk), .pwm(pwm_out[i]),
            .stop(stop[i]), .tach(tach_in[i]));
    end
    task automatic finish_test();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One APB transfer; the request holds until ready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin failures++; finish_test(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic meas(input int ch);
        hi = 0;
        repeat (PWM_STEPS * PWM_STEP_CYC) begin
            @(posedge ref_clk);
            if (pwm_out[ch] === 1'b1) hi++;
        end
    endtask
    task automatic t_reset();
        apb(1'b0, ADDR_ENABLE, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(pwm_out, 4'h0)
        apb(1'b0, 12'hFFC, 32'h0);
        `CHK({er, rd}, 33'h100000000)
        apb(1'b1, 12'h01C, 32'hFFFF);
        apb(1'b0, 12'h01C, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    // Manual mode with automatic-only options set, two pulses per rev, four-window average.
    task automatic t_manual();
        apb(1'b1, 12'h010, 32'h301E);
        apb(1'b1, 12'h014, 32'h80);
        apb(1'b1, ADDR_ENABLE, 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        `CHK(rd, 32'h80)
        meas(0);
        `CHK(hi, 128 * PWM_STEP_CYC)
        `CHK(pwm_out[1], 1'b0)
        repeat (12000) @(posedge ref_clk);
        apb(1'b0, 12'h01C, 32'h0);
        `CHK(rd[15:0], 16'(1000 / (2 * HALF) * 60))
    endtask
    task automatic t_stall();
        apb(1'b1, ADDR_INT_EN, 32'h1);
        stop[0] <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin @(posedge ref_clk); n++; end
        if (n >= 2000) begin failures++; finish_test(); end
        stop[0] <= 1'b0;
        `CHK(n > 440 && n < 520, 1'b1)
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        `CHK(rd[0], 1'b1)
        repeat (100) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        apb(1'b1, ADDR_INT_EN, 32'h0);
        @(posedge ref_clk);
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_INT_STAT, 32'h1);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        `CHK(rd[0], 1'b0)
    endtask
    // Auto: 75% start for 256 edges, fast ramp toward an unreachable target, no restart.
    task automatic t_auto();
        apb(1'b1, 12'h028, 32'hFFFF);
        apb(1'b1, 12'h020, 32'hF7);
        apb(1'b1, ADDR_ENABLE, 32'h3);
        repeat (10) @(posedge ref_clk);
        meas(1);
        `CHK(hi, 191 * PWM_STEP_CYC)
        apb(1'b0, 12'h024, 32'h0);
        `CHK(rd, 32'hBF)
        repeat (7400) @(posedge ref_clk);
        apb(1'b0, 12'h024, 32'h0);
        `CHK(rd, 32'hFF)
        stop[1] <= 1'b1;
        repeat (800) @(posedge ref_clk);
        apb(1'b0, 12'h02C, 32'h0);
        `CHK(rd[17:16], 2'h3)
        apb(1'b0, 12'h024, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(pwm_out[1], 1'b0)
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        `CHK(rd[1:0], 2'h2)
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_ENABLE, 32'h0);
        repeat (4) @(posedge ref_clk);
        `CHK(pwm_out, 4'h0)
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, stop} = '0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_manual();
        t_stall();
        t_auto();
        finish_test();
    end
endmodule // test_cooling_fan_speed_controller
bind fcs_top fcs_properties #(.NCH(NCH)) u_props (.ref_clk(ref_clk), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tach_in(tach_in),
    .pwm_out(pwm_out), .irq(irq));
`default_nettype wire
